// ===== rtl/irq_ctrl_map.svh
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH
// Register byte offsets
`define PRIO_REG0_OFS    8'h00
`define PRIO_REG1_OFS    8'h04
`define PRIO_REG2_OFS    8'h08
`define PRIO_REG3_OFS    8'h0C
`define SENSE_CTRL_OFS   8'h10
`define PERIPH_EN_OFS    8'h14
`define PERIPH_CLR_OFS   8'h18
`define PENDING_OFS      8'h1C
`define COND_REG_OFS     8'h20
`define WAKE_MASK_OFS    8'h24
// Field positions and values
`define PRIO_BIT_HIGH    5
`define PRIO_BIT_LOW     3
`define PRIO_RESET_VAL   8'hFF
`define COND_RESET_VAL   8'h2A
`define LVL0_CODE        2'h2
`define LVL3_CODE        2'h3
`define NUM_VEC          14
`define NUM_EXT          4
`define EXT_FIRST        2
`define WAKE_RESET_VAL   14'h20BF
`define VEC_BASE         16'hFFE0
`define VEC_RESET        16'hFFFE
`define VEC_TRAP         16'hFFFC
`endif

// ===== rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // Vector handed to the core
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [1:0]  level;
    logic [3:0]  index;
    logic        nmi;
  } vec_req_t;
  typedef enum logic [1:0] {
    RUN_ST  = 2'b00,
    WAIT_ST = 2'b01,
    STOP_ST = 2'b10
  } power_t;
  // Sense modes per external line
  typedef enum logic [1:0] {
    SENSE_FALL_LOW = 2'b00,
    SENSE_RISE     = 2'b01,
    SENSE_FALL     = 2'b10,
    SENSE_BOTH     = 2'b11
  } sense_t;
endpackage

// ===== rtl/nested_priority_irq_ctrl.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module nested_priority_irq_ctrl
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // Sources
  input  wire logic                  top_level_irq_i,
  input  wire logic [3:0][7:0]       ext_pins_i,
  input  wire logic [3:0][7:0]       ext_pin_sel_i,
  input  wire logic [`NUM_VEC-1:0]   periph_flag_i,
  input  wire logic                  trap_i,
  // Core sequencer
  input  wire logic                  core_boundary_i,
  input  wire logic                  core_ack_i,
  input  wire logic                  core_return_from_isr_i,
  input  wire logic [1:0]            core_return_from_isr_level_i,
  input  wire logic                  core_set_level_i,
  input  wire logic [1:0]            core_new_level_i,
  input  wire logic                  core_wait_i,
  input  wire logic                  core_stop_i,
  output vec_req_t                   vec_o,
  output logic                       wake_o,
  output logic [7:0]                 cond_o
);
  // ==========================================================
  // Level helpers
  // ==========================================================
  // Rank a level code 0..3 so codes compare as magnitudes
  function automatic logic [1:0] rank(input logic [1:0] code);
    unique case (code)
      2'b10:   rank = 2'h0;
      2'b01:   rank = 2'h1;
      2'b00:   rank = 2'h2;
      default: rank = 2'h3;
    endcase
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic [3:0][7:0]     prio_regs;
  logic [3:0][7:0]     next_prio_regs;
  logic [7:0]          sense;
  logic [7:0]          next_sense;
  logic [`NUM_VEC-1:0] periph_en;
  logic [`NUM_VEC-1:0] next_periph_en;
  logic [`NUM_VEC-1:0] wake_mask;
  logic [`NUM_VEC-1:0] next_wake_mask;
  logic [`NUM_VEC-1:0] pend;
  logic [`NUM_VEC-1:0] next_pend;
  logic [`NUM_EXT-1:0] ext_prev;
  logic                tli_prev;
  logic                trap_pend;
  logic                next_trap_pend;
  logic                reset_pend;
  logic                next_reset_pend;
  logic [7:0]          cond;
  logic [7:0]          next_cond;
  power_t              power;
  power_t              next_power;
  logic                stop_exit;
  logic                next_stop_exit;
  vec_req_t            vec;
  vec_req_t            next_vec;
  logic                ack;
  logic [31:0]         rdata;
  logic [31:0]         next_rdata;
  logic [`NUM_VEC-1:0] clr_pulse;

  // ==========================================================
  // Source detection
  // ==========================================================
  logic [`NUM_EXT-1:0] ext_line;
  logic [`NUM_EXT-1:0] ext_event;
  logic [`NUM_VEC-1:0] raw_set;
  logic                tli_edge;

  // Falling edge on the dedicated pin
  assign tli_edge = tli_prev & ~top_level_irq_i;

  genvar g;
  generate
    for (g = 0; g < `NUM_EXT; g++)
    begin : g_ext
      logic [1:0] md;
      assign md = sense[2*g +: 2];
      // Active line: any selected pin high (rise, both), else any low
      assign ext_line[g] = md[0] ? |(ext_pins_i[g] & ext_pin_sel_i[g])
        : |(~ext_pins_i[g] & ext_pin_sel_i[g]);
      // Sensitivity from the sense control register
      always_comb
      begin
        unique case (md)
          SENSE_FALL_LOW:         ext_event[g] = ext_line[g];
          SENSE_RISE, SENSE_FALL: ext_event[g] = ext_line[g] & ~ext_prev[g];
          SENSE_BOTH:             ext_event[g] = ext_line[g] ^ ext_prev[g];
        endcase
      end
    end
  endgenerate

  // Map each source onto its vector slot
  always_comb
  begin
    raw_set = periph_flag_i & periph_en;
    raw_set[0] = tli_edge;
    raw_set[1 +: 1] = periph_flag_i[1] & periph_en[1];
    raw_set[`EXT_FIRST +: `NUM_EXT] = ext_event;
  end

  // ==========================================================
  // Selection
  // ==========================================================
  logic [`NUM_VEC-1:0] req_live;
  logic                sel_found;
  logic [3:0]          sel_idx;
  logic [1:0]          sel_rank;
  logic [1:0]          cur_rank;
  logic [1:0]          code_i;

  assign cur_rank = rank({cond[`PRIO_BIT_HIGH], cond[`PRIO_BIT_LOW]});

  // Vector 0 first: lower index means higher hardware order
  always_comb
  begin
    sel_found = 1'b0;
    sel_idx   = 4'h0;
    sel_rank  = 2'h0;
    code_i    = 2'h0;
    // In stop exit only wake-capable sources compete
    req_live = stop_exit ? (pend & wake_mask) : pend;
    for (int i = `NUM_VEC - 1; i >= 0; i--)
    begin
      code_i = prio_regs[i/4][2*(i%4) +: 2];
      if (req_live[i] && (i == 0 || rank(code_i) >= sel_rank ||
          !sel_found))
      begin
        // Top irq ranks as highest level
        sel_found = 1'b1;
        sel_idx   = 4'(i);
        sel_rank  = (i == 0) ? 2'h3 : rank(code_i);
      end
    end
  end

  // ==========================================================
  // Service decision and core handshake
  // ==========================================================
  always_comb
  begin
    next_vec        = vec;
    next_pend       = (pend & ~clr_pulse) | raw_set;
    next_trap_pend  = trap_pend | trap_i;
    next_reset_pend = reset_pend;
    next_cond       = cond;
    next_power      = power;
    next_stop_exit  = stop_exit;
    // Level bits: popped on return, or set by instructions
    if (core_return_from_isr_i)
    begin
      next_cond[`PRIO_BIT_HIGH] = core_return_from_isr_level_i[1];
      next_cond[`PRIO_BIT_LOW]  = core_return_from_isr_level_i[0];
    end
    else if (core_set_level_i)
    begin
      next_cond[`PRIO_BIT_HIGH] = core_new_level_i[1];
      next_cond[`PRIO_BIT_LOW]  = core_new_level_i[0];
    end
    if (core_wait_i)
      next_power = WAIT_ST;
    else if (core_stop_i)
      next_power = STOP_ST;
    if (core_ack_i && vec.valid)
    begin
      // Handler entered: load level, drop edge latches
      next_cond[`PRIO_BIT_HIGH] = vec.level[1];
      next_cond[`PRIO_BIT_LOW]  = vec.level[0];
      next_vec.valid = 1'b0;
      next_stop_exit = 1'b0;
      if (vec.nmi && vec.addr == `VEC_RESET)
        next_reset_pend = 1'b0;
      else if (vec.nmi)
        next_trap_pend = trap_i;
      else
        next_pend[vec.index] = raw_set[vec.index] &
                               !(vec.index < `EXT_FIRST + `NUM_EXT);
    end
    else if (!vec.valid && core_boundary_i && power == RUN_ST)
    begin
      // One decision per instruction boundary
      if (reset_pend)
      begin
        next_vec = '{1'b1, `VEC_RESET, `LVL3_CODE, 4'h0, 1'b1};
      end
      else if (sel_found && sel_idx == 4'h0)
      begin
        // Top irq preempts trap handler
        next_vec = '{1'b1, `VEC_BASE + 16'h1A, `LVL3_CODE, 4'h0, 1'b0};
      end
      else if (trap_pend)
      begin
        next_vec = '{1'b1, `VEC_TRAP, `LVL3_CODE, 4'h0, 1'b1};
      end
      else if (sel_found && sel_rank > cur_rank)
      begin
        // Strictly higher level only
        next_vec.valid = 1'b1;
        next_vec.addr  = `VEC_BASE + 16'h1A - {11'h0, sel_idx, 1'b0};
        next_vec.level = prio_regs[sel_idx/4][2*(sel_idx%4) +: 2];
        next_vec.index = sel_idx;
        next_vec.nmi   = 1'b0;
      end
    end
    // Wake: any pending source from idle, wake-capable from stop
    if (power == WAIT_ST && (|pend || trap_pend))
      next_power = RUN_ST;
    if (power == STOP_ST && (|(pend & wake_mask) || trap_pend))
    begin
      next_power     = RUN_ST;
      next_stop_exit = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vec        <= '0;
      pend       <= '0;
      trap_pend  <= 1'b0;
      reset_pend <= 1'b1;
      cond       <= `COND_RESET_VAL;
      power      <= RUN_ST;
      stop_exit  <= 1'b0;
      ext_prev   <= '0;
      tli_prev   <= 1'b1;
    end
    else
    begin
      vec        <= next_vec;
      pend       <= next_pend;
      trap_pend  <= next_trap_pend;
      reset_pend <= next_reset_pend;
      cond       <= next_cond;
      power      <= next_power;
      stop_exit  <= next_stop_exit;
      ext_prev   <= ext_line;
      tli_prev   <= top_level_irq_i;
    end
  end

  // ==========================================================
  // Wishbone register file
  // ==========================================================
  logic wr_hit;
  assign wr_hit = cyc_i & stb_i & we_i & ~ack;

  // Writes, with level-0 field codes ignored
  always_comb
  begin
    next_prio_regs = prio_regs;
    next_sense     = sense;
    next_periph_en = periph_en;
    next_wake_mask = wake_mask;
    clr_pulse      = '0;
    if (wr_hit && sel_i[0])
    begin
      unique case (adr_i)
        `PRIO_REG0_OFS, `PRIO_REG1_OFS, `PRIO_REG2_OFS, `PRIO_REG3_OFS:
          for (int f = 0; f < 4; f++)
            if (dat_i[2*f +: 2] != `LVL0_CODE)
              next_prio_regs[adr_i[3:2]][2*f +: 2] = dat_i[2*f +: 2];
        `SENSE_CTRL_OFS: next_sense = dat_i[7:0];
        `PERIPH_EN_OFS:  next_periph_en = dat_i[`NUM_VEC-1:0];
        `PERIPH_CLR_OFS: clr_pulse = dat_i[`NUM_VEC-1:0];
        `WAKE_MASK_OFS:  next_wake_mask = dat_i[`NUM_VEC-1:0];
        default:         next_sense = sense;
      endcase
    end
    // Upper nibble of the last priority register is fixed
    next_prio_regs[3][7:4] = 4'hF;
  end

  // Read mux
  always_comb
  begin
    next_rdata = 32'h0;
    unique case (adr_i)
      `PRIO_REG0_OFS:  next_rdata = {24'h0, prio_regs[0]};
      `PRIO_REG1_OFS:  next_rdata = {24'h0, prio_regs[1]};
      `PRIO_REG2_OFS:  next_rdata = {24'h0, prio_regs[2]};
      `PRIO_REG3_OFS:  next_rdata = {24'h0, prio_regs[3]};
      `SENSE_CTRL_OFS: next_rdata = {24'h0, sense};
      `PERIPH_EN_OFS:  next_rdata = {18'h0, periph_en};
      `PENDING_OFS:    next_rdata = {15'h0, trap_pend, power, pend};
      `COND_REG_OFS:   next_rdata = {24'h0, cond};
      `WAKE_MASK_OFS:  next_rdata = {18'h0, wake_mask};
      default:         next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prio_regs <= {4{`PRIO_RESET_VAL}};
      sense     <= 8'h00;
      periph_en <= '0;
      wake_mask <= `WAKE_RESET_VAL;
      ack       <= 1'b0;
      rdata     <= 32'h0;
    end
    else
    begin
      prio_regs <= next_prio_regs;
      sense     <= next_sense;
      periph_en <= next_periph_en;
      wake_mask <= next_wake_mask;
      // One-cycle ack, dropped the cycle after
      ack       <= cyc_i & stb_i & ~ack;
      rdata     <= next_rdata;
    end
  end

  // Outputs
  assign ack_o  = ack;
  assign dat_o  = rdata;
  assign vec_o  = vec;
  assign cond_o = cond;
  assign wake_o = (power == RUN_ST);
endmodule

// ===== sim/core_model.sv
`timescale 1ns/1ps
// ==========
// Core sequencer stand-in, acks each vector after dly_i cycles
module core_model
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Controller side
  input  wire vec_req_t   vec_i,
  input  wire logic [3:0] dly_i,
  output logic            boundary_o,
  output logic            ack_o,
  output vec_req_t        seen_o,
  output logic [7:0]      cnt_o
);
  logic [3:0] wait_q;
  // Ack is one pulse; no ack in the cycle after an ack stops a double entry
  always_ff @(posedge clk_i)
  begin
    boundary_o <= !rst_i;
    ack_o <= 1'b0;
    if (rst_i)
    begin
      wait_q <= 4'h0;
      cnt_o <= 8'h0;
      seen_o <= '0;
    end
    else if (vec_i.valid && !ack_o && wait_q == dly_i)
    begin
      ack_o <= 1'b1;
      seen_o <= vec_i;
      cnt_o <= cnt_o + 8'h1;
      wait_q <= 4'h0;
    end
    else if (vec_i.valid && !ack_o)
      wait_q <= wait_q + 4'h1;
  end
endmodule

// ===== sim/irq_ctrl_props.sv
`timescale 1ns/1ps
// ==========
// Port checks on the interrupt controller
module irq_ctrl_props
  import irq_ctrl_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Core side
  input wire logic        core_ack_i,
  input wire logic        core_stop_i,
  input wire vec_req_t    vec_o,
  input wire logic        wake_o,
  input wire logic [7:0]  cond_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Bus answer
  property p_bus_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack late");
  property p_unmapped;
    ack_o && !we_i && adr_i > 8'h24 |-> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not 0");
  // ==========
  // Vector hand-over
  property p_vec_hold;
    vec_o.valid && !core_ack_i |=> vec_o.valid && $stable(vec_o.addr);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vec dropped");
  property p_vec_addr;
    vec_o.valid && !vec_o.nmi
      |-> vec_o.addr == 16'hFFFA - {11'h0, vec_o.index, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vec addr");
  property p_nmi_lvl;
    vec_o.valid && vec_o.nmi |-> vec_o.level == 2'h3;
  endproperty
  a_nmi_lvl: assert property (p_nmi_lvl) else $error("nmi level");
  // Level 3 blocks every maskable slot but the top one
  property p_masked;
    $rose(vec_o.valid) && !vec_o.nmi && vec_o.index != 4'h0
      |-> !$past(cond_o[5] && cond_o[3]);
  endproperty
  a_masked: assert property (p_masked) else $error("masked taken");
  property p_reset_lvl;
    $fell(rst_i) |-> cond_o[5] && cond_o[3];
  endproperty
  a_reset_lvl: assert property (p_reset_lvl) else $error("reset lvl");
  property p_reset_vec;
    $fell(rst_i) |-> ##[1:4] vec_o.valid && vec_o.addr == 16'hFFFE;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vec");
  property p_stop;
    core_stop_i |=> !wake_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_run_only;
    $rose(vec_o.valid) |-> $past(wake_o);
  endproperty
  a_run_only: assert property (p_run_only) else $error("vec asleep");
  // Main scenarios seen
  c_nmi: cover property (vec_o.valid && vec_o.nmi);
  c_mask: cover property (vec_o.valid && !vec_o.nmi);
  c_wake: cover property ($rose(wake_o));
endmodule
bind nested_priority_irq_ctrl irq_ctrl_props u_props (.*);

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %0h got %0h", n, e, v); end end
// ==========
// Self-checking bench for the interrupt controller
module tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, top_level_irq = 1, trap = 0;
  logic return_from_isr = 0, setl = 0, stop = 0, wt = 0;
  logic [1:0] lvl = 2'h0;
  logic [7:0] adr = 8'h0, last = 8'h0;
  logic [3:0] sel = 4'h0, dly = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  logic [3:0][7:0] pins = '1, psel = '0;
  logic [13:0] flag = 14'h0;
  wire [31:0] dq;
  wire [7:0] cond, cnt;
  wire ack, bnd, cack, wake;
  irq_ctrl_pkg::vec_req_t vec, seen;
  int error_cnt = 0, tests_run = 0, n;
  // Clock
  always #5 clk = ~clk;
  nested_priority_irq_ctrl uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dq), .ack_o(ack), .top_level_irq_i(top_level_irq), .ext_pins_i(pins),
    .ext_pin_sel_i(psel), .periph_flag_i(flag), .trap_i(trap),
    .core_boundary_i(bnd), .core_ack_i(cack), .core_return_from_isr_i(return_from_isr),
    .core_return_from_isr_level_i(lvl), .core_set_level_i(setl),
    .core_new_level_i(lvl), .core_wait_i(wt), .core_stop_i(stop),
    .vec_o(vec), .wake_o(wake), .cond_o(cond));
  core_model u_core (.clk_i(clk), .rst_i(rst), .vec_i(vec), .dly_i(dly),
    .boundary_o(bnd), .ack_o(cack), .seen_o(seen), .cnt_o(cnt));
  // ==========
  // Closing report
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task stall;
    error_cnt++;
    $display("unexpected wait exp done got timeout");
    summarize;
  endtask
  // Classic single cycle; the held request is released after ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = dq;
    if (n >= 20) stall;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Level load: s=1 is a software set, s=0 an interrupt return
  task lv(input logic s, input logic [1:0] c);
    setl <= s;
    return_from_isr <= !s;
    lvl <= c;
    @(posedge clk);
    setl <= 1'b0;
    return_from_isr <= 1'b0;
    @(posedge clk);
  endtask
  // Wait for the core to enter a handler, then compare its vector
  task want(input logic [15:0] e);
    n = 0;
    while (cnt === last && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) stall;
    last = cnt;
    `CHK("vector", e, seen.addr)
  endtask
  task quiet;
    repeat (12) @(posedge clk);
    `CHK("no entry", last, cnt)
  endtask
  // ==========
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    want(`VEC_RESET);
    `CHK("nmi", 1'b1, seen.nmi)
    wb(0, `COND_REG_OFS, 0);
    `CHK("cond", 32'h2A, rd)
    wb(0, `PRIO_REG3_OFS, 0);
    `CHK("prio3", 32'hFF, rd)
    wb(0, 8'h30, 0);
    `CHK("hole", 32'h0, rd)
    wb(1, `PRIO_REG0_OFS, 32'h64);
    wb(0, `PRIO_REG0_OFS, 0);
    `CHK("prio0", 32'h74, rd)
    $display("done reset and registers");
    wb(1, `PRIO_REG2_OFS, 32'hF1);
    wb(1, `PERIPH_EN_OFS, 32'h300);
    flag <= 14'h300;
    quiet;
    wb(0, `PENDING_OFS, 0);
    `CHK("pend", 2'h3, rd[9:8])
    lv(1, 2'h2);
    want(16'hFFE8);
    flag <= 14'h100;
    wb(1, `PERIPH_CLR_OFS, 32'h200);
    `CHK("cond level", 2'h0, {cond[5], cond[3]})
    quiet;
    lv(0, 2'h2);
    want(16'hFFEA);
    $display("done nesting");
    lv(1, 2'h3);
    quiet;
    flag <= 14'h0;
    wb(1, `PERIPH_CLR_OFS, 32'h100);
    wb(0, `PENDING_OFS, 0);
    `CHK("cleared", 1'b0, rd[8])
    lv(1, 2'h2);
    quiet;
    $display("done clearing");
    trap <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    want(`VEC_TRAP);
    top_level_irq <= 1'b0;
    want(16'hFFFA);
    top_level_irq <= 1'b1;
    lv(0, 2'h3);
    lv(0, 2'h2);
    $display("done nonmaskable");
    dly <= 4'h3;
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("asleep", 1'b0, wake)
    psel[0] <= 8'h01;
    pins[0] <= 8'hFE;
    n = 0;
    while (wake !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    pins[0] <= 8'hFF;
    `CHK("woken", 1'b1, wake)
    want(16'hFFF6);
    wb(0, `PENDING_OFS, 0);
    `CHK("auto clear", 1'b0, rd[2])
    // Idle mode: a source without wake capability still wakes it
    wt <= 1'b1;
    @(posedge clk);
    wt <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("idle", 1'b0, wake)
    flag <= 14'h100;
    repeat (3) @(posedge clk);
    `CHK("idle wake", 1'b1, wake)
    $display("done stop wake");
    summarize;
  end
endmodule
